// *** verilog/uehc_pkg.sv ***
// Package with register map, field layout and shared types of the endpoint handshake control block.
package uehc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ENDPOINT_CONTROL_BASE   = 16'h7F80;
  localparam logic [15:0] ENDPOINT_CONTROL_LAST   = 16'h7FBC;
  localparam logic [15:0] IRQ_STATUS_ADR = 16'h7FC0;
  localparam logic [15:0] IRQ_MASK_ADR   = 16'h7FC4;
  localparam logic [15:0] ENGINE_STS_ADR = 16'h7FC8;
  localparam int          EP_COUNT       = 16;
  localparam int          EP_IDX_LSB     = 2;

  // ----------------------------------------------------------------
  // Endpoint control field positions
  // ----------------------------------------------------------------
  localparam int TX_ISO_BIT  = 7;
  localparam int RX_ISO_BIT  = 6;
  localparam int IN_HI_BIT   = 5;
  localparam int OUT_HI_BIT  = 4;
  localparam int IN_LO_BIT   = 3;
  localparam int OUT_LO_BIT  = 2;
  localparam logic [7:0] ENDPOINT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ENDPOINT_CONTROL_WMASK = 8'hFC;

  // Handshake select codes.
  localparam logic [1:0] HS_DISABLED = 2'h0;
  localparam logic [1:0] HS_STALL    = 2'h1;
  localparam logic [1:0] HS_NORMAL   = 2'h2;
  localparam logic [1:0] HS_NAK      = 2'h3;

  // Largest payload the page manager stores.
  localparam logic [10:0] MAX_PAYLOAD = 11'h500;

  // Interrupt status bit positions.
  localparam int IRQ_W        = 4;
  localparam int IRQ_TX_DONE  = 0;
  localparam int IRQ_RX_START = 1;
  localparam int IRQ_STALL    = 2;
  localparam int IRQ_OVERSIZE = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UEHC_TOK_OUT   = 2'h0,
    UEHC_TOK_IN    = 2'h1,
    UEHC_TOK_SETUP = 2'h2,
    UEHC_TOK_NONE  = 2'h3
  } uehc_token_t;

  typedef enum logic [1:0] {
    UEHC_HS_NONE  = 2'h0,
    UEHC_HS_ACK   = 2'h1,
    UEHC_HS_NAK   = 2'h2,
    UEHC_HS_STALL = 2'h3
  } uehc_hs_t;

  // Token decoded by the serial engine.
  typedef struct packed {
    logic        valid;
    uehc_token_t kind;
    logic [3:0]  ep;
  } uehc_tok_t;

  // Answer to the serial engine.
  typedef struct packed {
    logic     valid;
    uehc_hs_t hs;
    logic     send_data;
  } uehc_resp_t;

  // Command to the packet mover dma.
  typedef struct packed {
    logic       tx_release;
    logic       tx_complete_push;
    logic       rx_alloc_start;
    logic [3:0] ep;
  } uehc_mover_t;

  typedef enum logic [2:0] {
    UEHC_ST_IDLE  = 3'b001,
    UEHC_ST_IN    = 3'b010,
    UEHC_ST_OUT   = 3'b100
  } uehc_state_t;

endpackage : uehc_pkg

// *** verilog/uehc_top.sv ***
// Endpoint handshake control: endpoint control registers, handshake choice and packet mover commands.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// - No per-endpoint buffers; payloads 0 to 1280 bytes.
// - Sixteen endpoint control registers from base address.
// - Isochronous IN always succeeds, queue completion.
// - Non-isochronous IN holds packet until ACK.
// - Successful transmit dequeues and releases buffer automatically.
// - Receive isochronous sends no OUT/SETUP handshake.
// - Address match starts page allocation, new record.
// - IN code 00 silent, 01 STALL.
// - IN code 10 ACK/NAK by queue, 11 NAK.
// - OUT code 00 silent, 01 STALL.
// - OUT code 10 by room, 11 NAK.
// - Token endpoint number selects control register.
// - Writes apply after endpoint transaction; last wins.
module uehc_top (
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [15:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire uehc_pkg::uehc_tok_t  token_i,
  input  wire logic                 addr_match_i,
  input  wire logic                 host_ack_i,
  input  wire logic                 xact_done_i,
  input  wire logic [15:0]          tx_queue_ready_i,
  input  wire logic [15:0]          rx_room_i,
  input  wire logic [10:0]          rx_byte_count_i,
  output uehc_pkg::uehc_resp_t      resp_o,
  output uehc_pkg::uehc_mover_t     mover_o,
  output logic                      irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0][7:0]          ctrl;
    logic [15:0][7:0]          pend_val;
    logic [15:0]               pend;
    logic [15:0]               busy;
    uehc_pkg::uehc_state_t     state;
    logic [3:0]                ep;
    logic [7:0]                act;
    logic [uehc_pkg::IRQ_W-1:0] sts;
    logic [uehc_pkg::IRQ_W-1:0] mask;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    uehc_pkg::uehc_resp_t      resp;
    uehc_pkg::uehc_mover_t     mover;
    logic                      irq;
    logic                      alloc_seen;
  } uehc_regs_t;

  uehc_regs_t r;
  uehc_regs_t next_r;

  // ----------------------------------------------------------------
  // Bus decode and per-endpoint fields
  // ----------------------------------------------------------------
  logic                       acc;
  logic                       is_ep;
  logic                       is_sts;
  logic                       is_mask;
  logic                       is_eng;
  logic                       unmapped;
  logic [3:0]                 widx;
  logic [7:0]                 wval;
  logic [31:0]                rd_word;

  logic                       tok_take;
  logic [7:0]                 sel;
  logic [1:0]                 in_code;
  logic [1:0]                 out_code;
  logic [1:0]                 tok_in_code;
  logic [1:0]                 tok_out_code;
  logic [uehc_pkg::IRQ_W-1:0] ev;

  logic [15:0][1:0]           ep_in_code;
  logic [15:0][1:0]           ep_out_code;
  logic [15:0]                ep_rx_iso;
  logic [15:0][7:0]           ep_view;

  // An access is taken once; the registered ready keeps the answer cycle from taking it again.
  assign acc      = psel_i && penable_i && !r.pready;
  assign is_ep    = (paddr_i >= uehc_pkg::ENDPOINT_CONTROL_BASE) && (paddr_i <= uehc_pkg::ENDPOINT_CONTROL_LAST)
                    && (paddr_i[1:0] == 2'h0);
  assign is_sts   = (paddr_i == uehc_pkg::IRQ_STATUS_ADR);
  assign is_mask  = (paddr_i == uehc_pkg::IRQ_MASK_ADR);
  assign is_eng   = (paddr_i == uehc_pkg::ENGINE_STS_ADR);
  assign unmapped = !(is_ep || is_sts || is_mask || is_eng);
  assign widx     = 4'(paddr_i[uehc_pkg::EP_IDX_LSB +: 6] - uehc_pkg::ENDPOINT_CONTROL_BASE[uehc_pkg::EP_IDX_LSB +: 6]);
  // Bits 1:0 belong to the toggle logic elsewhere and always read as zero here.
  assign wval     = pwdata_i[7:0] & uehc_pkg::ENDPOINT_CONTROL_WMASK;
  assign tok_take = token_i.valid && (token_i.kind != uehc_pkg::UEHC_TOK_NONE);

  // Firmware reads back a parked value at once, although the engine still runs on the old one.
  for (genvar n = 0; n < uehc_pkg::EP_COUNT; n++) begin : g_ep
    assign ep_in_code[n]  = {r.ctrl[n][uehc_pkg::IN_HI_BIT], r.ctrl[n][uehc_pkg::IN_LO_BIT]};
    assign ep_out_code[n] = {r.ctrl[n][uehc_pkg::OUT_HI_BIT], r.ctrl[n][uehc_pkg::OUT_LO_BIT]};
    assign ep_rx_iso[n]   = r.ctrl[n][uehc_pkg::RX_ISO_BIT];
    assign ep_view[n]     = r.pend[n] ? r.pend_val[n] : r.ctrl[n];
  end

  assign sel          = r.ctrl[token_i.ep];
  assign tok_in_code  = ep_in_code[token_i.ep];
  assign tok_out_code = ep_out_code[token_i.ep];
  assign in_code      = {r.act[uehc_pkg::IN_HI_BIT], r.act[uehc_pkg::IN_LO_BIT]};
  assign out_code     = {r.act[uehc_pkg::OUT_HI_BIT], r.act[uehc_pkg::OUT_LO_BIT]};

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero.
  always_comb begin
    rd_word = '0;
    if (is_ep) begin
      rd_word[7:0] = ep_view[widx];
    end else if (is_sts) begin
      rd_word[uehc_pkg::IRQ_W-1:0] = r.sts;
    end else if (is_mask) begin
      rd_word[uehc_pkg::IRQ_W-1:0] = r.mask;
    end else if (is_eng) begin
      rd_word[2:0]   = r.state;
      rd_word[7:4]   = r.ep;
      rd_word[31:16] = r.busy;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r         = r;
    ev             = '0;
    next_r.pready  = 1'b0;
    next_r.pslverr = 1'b0;
    next_r.resp    = '0;
    next_r.mover   = '0;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    // A bus access answers one cycle after its access phase starts.
    if (acc) begin
      next_r.pready  = 1'b1;
      next_r.pslverr = unmapped;
      if (pwrite_i) begin
        next_r.prdata = '0;
      end else begin
        next_r.prdata = rd_word;
      end
      if (is_ep && pwrite_i) begin
        // Writes to an endpoint in a transaction park until it ends; a later write overwrites.
        if (r.busy[widx]) begin
          next_r.pend[widx]     = 1'b1;
          next_r.pend_val[widx] = wval;
        end else begin
          next_r.ctrl[widx] = wval;
        end
      end
      if (is_mask && pwrite_i) begin
        next_r.mask = pwdata_i[uehc_pkg::IRQ_W-1:0];
      end
    end

    // ----------------------------------------------------------------
    // Token handling
    // ----------------------------------------------------------------
    // Tokens that come while a transaction is open are dropped.
    unique case (r.state)
      uehc_pkg::UEHC_ST_IDLE: begin
        if (tok_take) begin
          next_r.ep               = token_i.ep;
          next_r.act              = sel;
          next_r.alloc_seen       = 1'b0;
          next_r.busy[token_i.ep] = 1'b1;
          next_r.resp.valid       = 1'b1;
          if (token_i.kind == uehc_pkg::UEHC_TOK_IN) begin
            next_r.state = uehc_pkg::UEHC_ST_IN;
            unique case (tok_in_code)
              uehc_pkg::HS_DISABLED: begin
                next_r.resp.hs = uehc_pkg::UEHC_HS_NONE;
              end
              uehc_pkg::HS_STALL: begin
                next_r.resp.hs          = uehc_pkg::UEHC_HS_STALL;
                ev[uehc_pkg::IRQ_STALL] = 1'b1;
              end
              uehc_pkg::HS_NORMAL: begin
                // Queued data is sent as a data packet; an empty queue answers NAK.
                if (tx_queue_ready_i[token_i.ep]) begin
                  next_r.resp.hs        = uehc_pkg::UEHC_HS_ACK;
                  next_r.resp.send_data = 1'b1;
                end else begin
                  next_r.resp.hs = uehc_pkg::UEHC_HS_NAK;
                end
              end
              uehc_pkg::HS_NAK: begin
                next_r.resp.hs = uehc_pkg::UEHC_HS_NAK;
              end
            endcase
          end else begin
            next_r.state = uehc_pkg::UEHC_ST_OUT;
            unique case (tok_out_code)
              uehc_pkg::HS_DISABLED: begin
                next_r.resp.hs = uehc_pkg::UEHC_HS_NONE;
              end
              uehc_pkg::HS_STALL: begin
                next_r.resp.hs          = uehc_pkg::UEHC_HS_STALL;
                ev[uehc_pkg::IRQ_STALL] = 1'b1;
              end
              uehc_pkg::HS_NORMAL: begin
                if (rx_room_i[token_i.ep]) begin
                  next_r.resp.hs = uehc_pkg::UEHC_HS_ACK;
                end else begin
                  next_r.resp.hs = uehc_pkg::UEHC_HS_NAK;
                end
              end
              uehc_pkg::HS_NAK: begin
                next_r.resp.hs = uehc_pkg::UEHC_HS_NAK;
              end
            endcase
            // An isochronous receive endpoint stays silent whatever its code says.
            if (ep_rx_iso[token_i.ep]) begin
              next_r.resp.hs = uehc_pkg::UEHC_HS_NONE;
            end
          end
        end
      end
      uehc_pkg::UEHC_ST_IN: begin
        if (xact_done_i) begin
          next_r.state = uehc_pkg::UEHC_ST_IDLE;
          // Only a sent data packet can be released; a NAK or STALL leaves the queue alone.
          if (in_code == uehc_pkg::HS_NORMAL
              && tx_queue_ready_i[r.ep]
              && (r.act[uehc_pkg::TX_ISO_BIT] || host_ack_i)) begin
            next_r.mover.tx_release       = 1'b1;
            next_r.mover.tx_complete_push = 1'b1;
            next_r.mover.ep               = r.ep;
            ev[uehc_pkg::IRQ_TX_DONE]     = 1'b1;
          end
        end
      end
      uehc_pkg::UEHC_ST_OUT: begin
        // Storage is shared by all endpoints, so allocation starts on the first address match unless the OUT code is 00.
        if (addr_match_i && !r.alloc_seen && out_code != uehc_pkg::HS_DISABLED) begin
          next_r.mover.rx_alloc_start = 1'b1;
          next_r.alloc_seen           = 1'b1;
          next_r.mover.ep             = r.ep;
          ev[uehc_pkg::IRQ_RX_START]  = 1'b1;
        end
        // Oversize is only reported; firmware decides what to do with the record.
        if (rx_byte_count_i > uehc_pkg::MAX_PAYLOAD) begin
          ev[uehc_pkg::IRQ_OVERSIZE] = 1'b1;
        end
        if (xact_done_i) begin
          next_r.state = uehc_pkg::UEHC_ST_IDLE;
        end
      end
      default: begin
        next_r.state = uehc_pkg::UEHC_ST_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Transaction end
    // ----------------------------------------------------------------
    // Parked control values land once the endpoint's transaction is over.
    if (r.state != uehc_pkg::UEHC_ST_IDLE && xact_done_i) begin
      next_r.busy[r.ep] = 1'b0;
      if (r.pend[r.ep]) begin
        next_r.ctrl[r.ep] = r.pend_val[r.ep];
        next_r.pend[r.ep] = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // Interrupt status
    // ----------------------------------------------------------------
    // Write-one-to-clear; a new event in the same cycle wins.
    if (acc && pwrite_i && is_sts) begin
      next_r.sts = r.sts & ~pwdata_i[uehc_pkg::IRQ_W-1:0];
    end
    next_r.sts = next_r.sts | ev;
    next_r.irq = |(next_r.sts & next_r.mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      r.ctrl       <= {uehc_pkg::EP_COUNT{uehc_pkg::ENDPOINT_CONTROL_RESET}};
      r.pend_val   <= '0;
      r.pend       <= '0;
      r.busy       <= '0;
      r.state      <= uehc_pkg::UEHC_ST_IDLE;
      r.ep         <= '0;
      r.act        <= uehc_pkg::ENDPOINT_CONTROL_RESET;
      r.sts        <= '0;
      r.mask       <= '0;
      r.prdata     <= '0;
      r.pready     <= 1'b0;
      r.pslverr    <= 1'b0;
      r.resp       <= '0;
      r.mover      <= '0;
      r.irq        <= 1'b0;
      r.alloc_seen <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output comes straight from the state register, so none of them can glitch.
  assign prdata_o  = r.prdata;
  assign pready_o  = r.pready;
  assign pslverr_o = r.pslverr;
  assign resp_o    = r.resp;
  assign mover_o   = r.mover;
  assign irq_o     = r.irq;

endmodule : uehc_top

// *** testbench/uehc_assertions.sv ***
// Concurrent checks on the ports of the endpoint handshake control block.
`timescale 1ns/1ps
module uehc_assertions (
  input wire logic                  core_clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic [15:0]           paddr_i,
  input wire logic                  pready_o,
  input wire logic                  pslverr_o,
  input wire uehc_pkg::uehc_tok_t   token_i,
  input wire logic                  addr_match_i,
  input wire logic                  xact_done_i,
  input wire logic [15:0]           tx_queue_ready_i,
  input wire logic [15:0]           rx_room_i,
  input wire uehc_pkg::uehc_resp_t  resp_o,
  input wire uehc_pkg::uehc_mover_t mover_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic acc;
  assign acc = psel_i && penable_i && !pready_o;
  apb_wait_a: assert property (acc |=> pready_o) else $error("no ready after access");
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
  unmapped_err_a: assert property (acc && paddr_i > 16'h7FC8 |=> pslverr_o) else $error("no error");
  ep_map_a: assert property (acc && paddr_i[15:6] == 10'h1FE && paddr_i[1:0] == 2'h0 |=> !pslverr_o)
    else $error("control slot refused");
  resp_tok_a: assert property (resp_o.valid |-> $past(token_i.valid)) else $error("stray answer");
  in_empty_a: assert property (token_i.valid && token_i.kind == uehc_pkg::UEHC_TOK_IN
    && !tx_queue_ready_i[token_i.ep] |=> resp_o.hs != uehc_pkg::UEHC_HS_ACK) else $error("ack on empty queue");
  out_room_a: assert property (token_i.valid && token_i.kind == uehc_pkg::UEHC_TOK_OUT
    && !rx_room_i[token_i.ep] |=> resp_o.hs != uehc_pkg::UEHC_HS_ACK) else $error("ack without room");
  rel_done_a: assert property (mover_o.tx_release |-> $past(xact_done_i) && mover_o.tx_complete_push)
    else $error("release off completion");
  alloc_match_a: assert property (mover_o.rx_alloc_start |-> $past(addr_match_i))
    else $error("alloc without match");
  cover property (resp_o.valid && resp_o.hs == uehc_pkg::UEHC_HS_STALL);
  cover property (mover_o.tx_release);
  cover property (pslverr_o);
endmodule : uehc_assertions
bind uehc_top uehc_assertions u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .token_i(token_i),
  .addr_match_i(addr_match_i), .xact_done_i(xact_done_i), .tx_queue_ready_i(tx_queue_ready_i),
  .rx_room_i(rx_room_i), .resp_o(resp_o), .mover_o(mover_o));

// *** testbench/uehc_host_model.sv ***
// Behavioural host that issues token transactions and closes them.
`timescale 1ns/1ps
module uehc_host_model (
  input  wire logic                  core_clk_i,
  input  wire uehc_pkg::uehc_resp_t  resp_i,
  input  wire uehc_pkg::uehc_mover_t mover_i,
  output uehc_pkg::uehc_tok_t        token_o,
  output logic                       addr_match_o,
  output logic                       host_ack_o,
  output logic                       xact_done_o
);
  logic sent;
  initial begin
    sent = 1'b0;
    token_o = '0;
    addr_match_o = 1'b0;
    host_ack_o = 1'b0;
    xact_done_o = 1'b0;
  end
  task automatic start(input uehc_pkg::uehc_token_t k, input logic [3:0] ep, output uehc_pkg::uehc_hs_t hs);
    @(posedge core_clk_i);
    token_o <= '{1'b1, k, ep};
    @(posedge core_clk_i);
    token_o <= '{1'b0, uehc_pkg::UEHC_TOK_NONE, ~ep};
    #1 hs = resp_i.hs;
    sent = resp_i.send_data;
  endtask : start
  // The ack level means nothing outside the end strobe, so it shows the inverse there.
  task automatic finish(input logic m, input logic ak, output logic alloc, output logic rel);
    @(posedge core_clk_i);
    addr_match_o <= m;
    @(posedge core_clk_i);
    addr_match_o <= 1'b0;
    xact_done_o <= 1'b1;
    host_ack_o <= ak;
    #1 alloc = mover_i.rx_alloc_start;
    @(posedge core_clk_i);
    xact_done_o <= 1'b0;
    host_ack_o <= ~ak;
    #1 rel = mover_i.tx_release;
  endtask : finish
endmodule : uehc_host_model

// *** testbench/testbench.sv ***
// Self-checking testbench of the endpoint handshake control block.
`timescale 1ns/1ps
module testbench;
  logic                  clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [15:0]           paddr = '0, tq = '0, rr = '0;
  logic [31:0]           pwdata = '0, prdata, r;
  logic [10:0]           rbc = '0;
  logic                  pready, pslverr, irq, am, ack, done, e, a, l;
  int                    fail_count = 0, num_checks = 0;
  uehc_pkg::uehc_tok_t   tok;
  uehc_pkg::uehc_resp_t  resp;
  uehc_pkg::uehc_mover_t mov;
  uehc_pkg::uehc_hs_t    hs;
  always #20 clk = ~clk;
  uehc_top u_dut (.core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .token_i(tok), .addr_match_i(am), .host_ack_i(ack), .xact_done_i(done), .tx_queue_ready_i(tq),
    .rx_room_i(rr), .rx_byte_count_i(rbc), .resp_o(resp), .mover_o(mov), .irq_o(irq));
  uehc_host_model u_host (.core_clk_i(clk), .resp_i(resp), .mover_i(mov), .token_o(tok),
    .addr_match_o(am), .host_ack_o(ack), .xact_done_o(done));
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    num_checks++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, m, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  function automatic uehc_pkg::uehc_hs_t want(input logic [1:0] c, input logic ok);
    case (c)
      2'h1: return uehc_pkg::UEHC_HS_STALL;
      2'h2: return ok ? uehc_pkg::UEHC_HS_ACK : uehc_pkg::UEHC_HS_NAK;
      2'h3: return uehc_pkg::UEHC_HS_NAK;
      default: return uehc_pkg::UEHC_HS_NONE;
    endcase
  endfunction : want
  task automatic t_regs();
    apb(0, 16'h7FBC, '0);
    chk(r, 32'h0, "ep15 reset");
    apb(1, 16'h7F8C, 32'hFF);
    apb(0, 16'h7F8C, '0);
    chk(r, 32'hFC, "ep3 readback");
    apb(0, 16'h7FD0, '0);
    chk({r[30:0], e}, 32'h1, "unmapped");
  endtask : t_regs
  // Only the addressed endpoint's queue or room bit differs, so a wrong index shows.
  task automatic t_codes(input logic o);
    for (int c = 0; c < 4; c++) begin
      for (int q = 0; q < 2; q++) begin
        apb(1, o ? 16'h7F9C : 16'h7F88, 32'(o ? (c / 2) * 16 + (c % 2) * 4 : (c / 2) * 32 + (c % 2) * 8));
        tq <= q ? 16'h0004 : 16'hFFFB;
        rr <= q ? 16'h0080 : 16'hFF7F;
        u_host.start(o ? uehc_pkg::UEHC_TOK_OUT : uehc_pkg::UEHC_TOK_IN, o ? 4'h7 : 4'h2, hs);
        chk(hs, want(c[1:0], q[0]), "code");
        u_host.finish(o, 1, a, l);
        chk({a, l}, {o && c != 0, !o && c == 2 && q == 1}, "mover");
      end
    end
  endtask : t_codes
  task automatic t_iso();
    tq <= 16'hFFFF;
    apb(1, 16'h7FA4, 32'hA0);
    u_host.start(uehc_pkg::UEHC_TOK_IN, 4'h9, hs);
    u_host.finish(0, 0, a, l);
    chk({hs, u_host.sent, l}, {uehc_pkg::UEHC_HS_ACK, 1'b1, 1'b1}, "iso in");
    chk(mov.ep, 32'h9, "release ep");
    apb(1, 16'h7FA4, 32'h50);
    rbc <= 11'h501;
    for (int k = 0; k < 3; k += 2) begin
      u_host.start(uehc_pkg::uehc_token_t'(k), 4'h9, hs);
      u_host.finish(1, 0, a, l);
      chk(hs, uehc_pkg::UEHC_HS_NONE, "iso out");
    end
    rbc <= '0;
  endtask : t_iso
  task automatic t_park();
    apb(1, 16'h7F94, 32'h20);
    u_host.start(uehc_pkg::UEHC_TOK_IN, 4'h5, hs);
    apb(0, 16'h7FC8, '0);
    chk(r, 32'h00200052, "engine status");
    apb(1, 16'h7F94, 32'h28);
    apb(0, 16'h7F94, '0);
    chk(r, 32'h28, "parked read");
    apb(1, 16'h7F94, 32'h00);
    apb(1, 16'h7F94, 32'h08);
    u_host.finish(0, 1, a, l);
    chk(l, 1, "old code kept");
    u_host.start(uehc_pkg::UEHC_TOK_IN, 4'h5, hs);
    u_host.finish(0, 1, a, l);
    chk(hs, uehc_pkg::UEHC_HS_STALL, "last write");
  endtask : t_park
  task automatic t_irq();
    apb(0, 16'h7FC0, '0);
    chk({r, irq}, {32'hF, 1'b0}, "status");
    apb(1, 16'h7FC4, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1, "irq up");
    apb(1, 16'h7FC0, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 0, "irq cleared");
    apb(0, 16'h7FC0, '0);
    chk(r, 32'hE, "w1c");
  endtask : t_irq
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    t_regs();
    t_codes(0);
    t_codes(1);
    t_iso();
    t_park();
    t_irq();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule : testbench
